// file: core/p2mii_map.svh
/*
  Offsets, field positions, reset values and fixed patterns of the
  port-two transceiver management register set.
  Assumes a 32-bit Avalon-MM slave with byte addresses; a register
  index is turned into a byte address by multiplying it by four.
*/
`ifndef P2MII_MAP_SVH
`define P2MII_MAP_SVH

// Register indexes; byte address is four times the index.
`define P2M_CTRL_IDX 4'h0
`define P2M_STS_IDX 4'h2
`define P2M_IDL_IDX 4'h4
`define P2M_IDH_IDX 4'h6
`define P2M_ISTS_IDX 4'h8
`define P2M_IMSK_IDX 4'h9

// Basic control register fields.
`define P2M_C_RESET 15
`define P2M_C_LOOP 14
`define P2M_C_SPEED 13
`define P2M_C_ANEN 12
`define P2M_C_PDOWN 11
`define P2M_C_ISOL 10
`define P2M_C_RESTART 9
`define P2M_C_DUPLEX 8
`define P2M_C_COLL 7
`define P2M_C_XALG 5
`define P2M_C_XFORCE 4
`define P2M_C_XDIS 3
`define P2M_C_TXDIS 1

// Bits that software can store, and the reset value of the register.
`define P2M_CTRL_WMASK 16'h793f
`define P2M_CTRL_RST 16'h3120

// Basic status register: fixed ones, and the live bit positions.
`define P2M_STS_FIXED 16'h7808
`define P2M_S_ANDONE 5
`define P2M_S_LINK 2

// Interrupt status bits.
`define P2M_I_LINK 0
`define P2M_I_ANDONE 1

`endif

// file: core/p2mii_pkg.sv
/*
  Types of the port-two transceiver management register set.
  Assumes nothing of its surroundings.
*/
package p2mii_pkg;

  // Phase of the register bus handshake.
  typedef enum logic [0:0] {
    P2M_IDLE = 1'b0,
    P2M_ACK = 1'b1
  } p2mii_phase_t;

  // All state of the block in one record.
  typedef struct packed {
    p2mii_phase_t phase;
    logic wait_n;
    logic [31:0] rdata;
    logic [15:0] ctrl;
    logic restart;
    logic lk_s1;
    logic lk_s2;
    logic lk_prev;
    logic an_s1;
    logic an_s2;
    logic an_prev;
    logic [1:0] int_sts;
    logic [1:0] int_msk;
    logic irq;
  } p2mii_state_t;

endpackage

// file: core/p2mii_regs.sv
/*
  Management register set of the port-two transceiver: basic control,
  basic status, two identifier words and an interrupt pair, reached over
  an Avalon-MM slave with waitrequest.
  Assumes one clock, a synchronous active-low reset, a clock enable from
  the same domain, and link and negotiation levels from the transceiver
  that are asynchronous to this clock.
*/
// The Avalon-MM interface to the registers was chosen for this implementation.
// Overview of operation
// - Basic control register at index 0x00 drives port-two transceiver.
// - Far-end loopback bit loops port one receive at port two sublayer.
// - autoneg_enable set enables auto-negotiation, clear disables it.
// - Without negotiation, forced speed and duplex bits choose the mode.
// - Writing one to autoneg_restart restarts negotiation; zero does nothing.
// - Power-down bit powers transceiver down; clearing restores operation.
// - crossover_algorithm_select picks standard or native crossover style.
// - Crossover disable and forced crossed wiring bits; zero is normal.
// - Transmit-disable bit stops the transmitter; clearing allows sending.
// - Read-only basic status register stands at index 0x02.
// - Status bits 14 to 11 read one, all four speed modes.
// - Status bit 15 reads zero, no four-pair signalling.
// - Status bit 5 shows negotiation complete, zero after reset.
// - Status bit 3 reads one, negotiation capable.
// - Bit 0, preamble, jabber and bits 10 to 7 read zero.
// - Index 0x04 returns fixed low identifier word.
// - Index 0x06 returns fixed high identifier word in bits 15-0.
`timescale 1ns/1ps
`include "p2mii_map.svh"
`default_nettype none

module p2mii_regs
  import p2mii_pkg::*;
#(
  // Identifier words; the values are arbitrary.
  parameter logic [15:0] PHY_ID_LOW = 16'h0a5c,
  parameter logic [15:0] PHY_ID_HIGH = 16'h0c35
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic link_up_in,
  input wire logic autoneg_done_in,
  output logic far_end_loopback_out,
  output logic autoneg_enable_out,
  output logic speed_select_fast_out,
  output logic full_duplex_out,
  output logic power_down_out,
  output logic autoneg_restart_out,
  output logic crossover_algorithm_select_out,
  output logic auto_crossover_disable_out,
  output logic force_crossed_wiring_out,
  output logic tx_disable_out,
  output logic irq_out
);

  p2mii_state_t st_ff;
  p2mii_state_t nxt_st;

  logic req;
  logic take;
  logic [3:0] idx;
  logic addr_ok;
  logic [15:0] sts_word;

  // A request is taken only in the idle phase, so each one is answered
  // exactly once even if the master keeps it up across the ack edge.
  assign req = avs_read_in | avs_write_in;
  assign take = req & (st_ff.phase == P2M_IDLE);
  assign idx = avs_address_in[5:2];
  assign addr_ok = (avs_address_in[1:0] == 2'h0);

  // Status word: fixed capability pattern plus the two live bits.
  always_comb begin
    sts_word = `P2M_STS_FIXED;
    sts_word[`P2M_S_ANDONE] = st_ff.an_s2;
    sts_word[`P2M_S_LINK] = st_ff.lk_s2;
  end

  // Next-state logic for the whole block.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.restart = 1'b0;
    // Two-flop synchronisers; the first stage feeds only the second.
    nxt_st.lk_s1 = link_up_in;
    nxt_st.lk_s2 = st_ff.lk_s1;
    nxt_st.lk_prev = st_ff.lk_s2;
    nxt_st.an_s1 = autoneg_done_in;
    nxt_st.an_s2 = st_ff.an_s1;
    nxt_st.an_prev = st_ff.an_s2;
    case (st_ff.phase)
      P2M_IDLE: begin
        if (take) begin
          nxt_st.phase = P2M_ACK;
          nxt_st.wait_n = 1'b1;
          nxt_st.rdata = 32'h0;
          if (avs_read_in && addr_ok) begin
            case (idx)
              `P2M_CTRL_IDX: nxt_st.rdata = {16'h0, st_ff.ctrl};
              `P2M_STS_IDX: nxt_st.rdata = {16'h0, sts_word};
              `P2M_IDL_IDX: nxt_st.rdata = {16'h0, PHY_ID_LOW};
              `P2M_IDH_IDX: nxt_st.rdata = {16'h0, PHY_ID_HIGH};
              `P2M_ISTS_IDX: nxt_st.rdata = {30'h0, st_ff.int_sts};
              `P2M_IMSK_IDX: nxt_st.rdata = {30'h0, st_ff.int_msk};
              default: nxt_st.rdata = 32'h0;
            endcase
          end
        end
      end
      P2M_ACK: begin
        // The write lands on the same edge the master sees the answer.
        nxt_st.phase = P2M_IDLE;
        nxt_st.wait_n = 1'b0;
        if (avs_write_in && addr_ok) begin
          case (idx)
            `P2M_CTRL_IDX: begin
              // Bits outside the mask stay zero; spare bits 2 and 0 are inside it and store.
              if (avs_byteenable_in[1]) begin
                nxt_st.ctrl[15:8] = avs_writedata_in[15:8] &
                  8'(`P2M_CTRL_WMASK >> 8);
                nxt_st.restart = avs_writedata_in[`P2M_C_RESTART];
              end
              if (avs_byteenable_in[0]) begin
                nxt_st.ctrl[7:0] = avs_writedata_in[7:0] &
                  8'(`P2M_CTRL_WMASK);
              end
            end
            `P2M_IMSK_IDX: begin
              if (avs_byteenable_in[0]) begin
                nxt_st.int_msk = avs_writedata_in[1:0];
              end
            end
            `P2M_ISTS_IDX: begin
              if (avs_byteenable_in[0]) begin
                nxt_st.int_sts = st_ff.int_sts & ~avs_writedata_in[1:0];
              end
            end
            default: nxt_st.int_msk = st_ff.int_msk;
          endcase
        end
      end
      default: begin
        nxt_st.phase = P2M_IDLE;
        nxt_st.wait_n = 1'b0;
      end
    endcase
    // Hardware sets come after the clear, so an event is never lost.
    if (st_ff.lk_s2 != st_ff.lk_prev) begin
      nxt_st.int_sts[`P2M_I_LINK] = 1'b1;
    end
    if (st_ff.an_s2 && !st_ff.an_prev) begin
      nxt_st.int_sts[`P2M_I_ANDONE] = 1'b1;
    end
    nxt_st.irq = |(nxt_st.int_sts & nxt_st.int_msk);
  end

  // One register for all state; the clock enable freezes everything.
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      st_ff <= '{phase: P2M_IDLE, wait_n: 1'b0, rdata: 32'h0,
                 ctrl: `P2M_CTRL_RST, restart: 1'b0, lk_s1: 1'b0,
                 lk_s2: 1'b0, lk_prev: 1'b0, an_s1: 1'b0, an_s2: 1'b0,
                 an_prev: 1'b0, int_sts: 2'h0, int_msk: 2'h0,
                 irq: 1'b0};
    end else if (ce_in) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs are taken straight from the state register.
  assign avs_readdata_out = st_ff.rdata;
  assign avs_waitrequest_out = ~st_ff.wait_n;
  assign far_end_loopback_out = st_ff.ctrl[`P2M_C_LOOP];
  assign autoneg_enable_out = st_ff.ctrl[`P2M_C_ANEN];
  // The transceiver only honours these two while negotiation is off.
  assign speed_select_fast_out = st_ff.ctrl[`P2M_C_SPEED];
  assign full_duplex_out = st_ff.ctrl[`P2M_C_DUPLEX];
  assign power_down_out = st_ff.ctrl[`P2M_C_PDOWN];
  assign autoneg_restart_out = st_ff.restart;
  assign crossover_algorithm_select_out = st_ff.ctrl[`P2M_C_XALG];
  assign auto_crossover_disable_out = st_ff.ctrl[`P2M_C_XDIS];
  assign force_crossed_wiring_out = st_ff.ctrl[`P2M_C_XFORCE];
  assign tx_disable_out = st_ff.ctrl[`P2M_C_TXDIS];
  assign irq_out = st_ff.irq;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Steps of one bus transfer, used by several checks below.
  sequence s_take_rd(logic [3:0] i);
    ce_in && take && avs_read_in && addr_ok && idx == i;
  endsequence

  sequence s_ack_wr(logic [3:0] i);
    ce_in && st_ff.phase == P2M_ACK && avs_write_in && addr_ok &&
      idx == i;
  endsequence

  // A taken request is answered on the very next edge, for one cycle;
  // a low clock enable on the answer edge only stretches the answer.
  a_bus_answer: assert property (
    ce_in && take |=> !avs_waitrequest_out ##1
      (avs_waitrequest_out || !$past(ce_in)))
    else $error("bus answer not one cycle after request");

  a_ctrl_store: assert property (
    s_ack_wr(`P2M_CTRL_IDX) and avs_byteenable_in == 4'hf |=>
      st_ff.ctrl == ($past(avs_writedata_in[15:0]) & `P2M_CTRL_WMASK))
    else $error("control write not stored as masked");

  a_loop_follow: assert property (
    s_ack_wr(`P2M_CTRL_IDX) and avs_byteenable_in[1] |=>
      far_end_loopback_out == $past(avs_writedata_in[`P2M_C_LOOP]))
    else $error("loopback output does not follow write");

  a_anen_follow: assert property (
    s_ack_wr(`P2M_CTRL_IDX) and avs_byteenable_in[1] |=>
      autoneg_enable_out == $past(avs_writedata_in[`P2M_C_ANEN]))
    else $error("negotiation enable does not follow write");

  a_forced_mode: assert property (
    s_ack_wr(`P2M_CTRL_IDX) and avs_byteenable_in[1] |=>
      speed_select_fast_out == $past(avs_writedata_in[`P2M_C_SPEED]) &&
      full_duplex_out == $past(avs_writedata_in[`P2M_C_DUPLEX]))
    else $error("forced speed or duplex wrong");

  a_restart_pulse: assert property (
    s_ack_wr(`P2M_CTRL_IDX) and avs_byteenable_in[1] and
      avs_writedata_in[`P2M_C_RESTART] |=> autoneg_restart_out ##1
      (!autoneg_restart_out || !$past(ce_in)))
    else $error("restart is not a single pulse");

  a_pdown_follow: assert property (
    s_ack_wr(`P2M_CTRL_IDX) and avs_byteenable_in[1] |=>
      power_down_out == $past(avs_writedata_in[`P2M_C_PDOWN]))
    else $error("power down does not follow write");

  a_xover_follow: assert property (
    s_ack_wr(`P2M_CTRL_IDX) and avs_byteenable_in[0] |=>
      auto_crossover_disable_out == $past(avs_writedata_in[3]) &&
      force_crossed_wiring_out == $past(avs_writedata_in[4]) &&
      crossover_algorithm_select_out == $past(avs_writedata_in[5]))
    else $error("crossover controls do not follow write");

  a_txdis_follow: assert property (
    s_ack_wr(`P2M_CTRL_IDX) and avs_byteenable_in[0] |=>
      tx_disable_out == $past(avs_writedata_in[`P2M_C_TXDIS]))
    else $error("transmit disable does not follow write");

  a_sts_fixed: assert property (
    s_take_rd(`P2M_STS_IDX) |=> avs_readdata_out[15:11] == 5'h0f &&
      avs_readdata_out[10:6] == 5'h0 && avs_readdata_out[3] &&
      avs_readdata_out[1:0] == 2'h0 && !avs_waitrequest_out)
    else $error("status capability pattern wrong");

  a_sts_live: assert property (
    s_take_rd(`P2M_STS_IDX) |=>
      avs_readdata_out[`P2M_S_ANDONE] == $past(st_ff.an_s2) &&
      avs_readdata_out[`P2M_S_LINK] == $past(st_ff.lk_s2))
    else $error("live status bits wrong");

  a_link_sync: assert property (
    (ce_in && $stable(link_up_in)) [*3] |-> st_ff.lk_s2 == link_up_in)
    else $error("link status not synchronised in two cycles");

  a_id_low: assert property (
    s_take_rd(`P2M_IDL_IDX) |=> avs_readdata_out == {16'h0, PHY_ID_LOW})
    else $error("low identifier wrong");

  a_id_high: assert property (
    s_take_rd(`P2M_IDH_IDX) |=> avs_readdata_out == {16'h0, PHY_ID_HIGH})
    else $error("high identifier wrong");

  a_ro_zero: assert property (
    s_take_rd(`P2M_CTRL_IDX) |=> avs_readdata_out[`P2M_C_RESET] == 1'b0 &&
      avs_readdata_out[`P2M_C_ISOL] == 1'b0 &&
      avs_readdata_out[`P2M_C_COLL] == 1'b0 &&
      avs_readdata_out[`P2M_C_RESTART] == 1'b0)
    else $error("unsupported control bit reads one");

  a_event_sticky: assert property (
    ce_in && st_ff.lk_s2 != st_ff.lk_prev |=> st_ff.int_sts[`P2M_I_LINK])
    else $error("link event not captured");

  a_irq_level: assert property (
    irq_out == |(st_ff.int_sts & st_ff.int_msk))
    else $error("interrupt level disagrees with status and mask");

endmodule

`default_nettype wire

// file: test/p2mii_regs_test.sv
/*
  Self-checking bench of the port-two transceiver register set.
  Assumes the design files under core/ are compiled before it.
*/
`timescale 1ns/1ps
`include "p2mii_map.svh"
`default_nettype none

module p2mii_regs_test;
  // Identifier words for the instance; the values are arbitrary.
  localparam logic [15:0] ID_LO = 16'h5a3c;
  localparam logic [15:0] ID_HI = 16'h0c71;

  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic ce_in = 1'b1;
  logic ce_rand = 1'b0;
  logic [5:0] avs_address_in = 6'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h00000000;
  logic [3:0] avs_byteenable_in = 4'hf;
  logic link_up_in = 1'b0;
  logic autoneg_done_in = 1'b0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out, autoneg_restart_out, irq_out;
  logic far_end_loopback_out, autoneg_enable_out, speed_select_fast_out;
  logic full_duplex_out, power_down_out, crossover_algorithm_select_out;
  logic auto_crossover_disable_out, force_crossed_wiring_out;
  logic tx_disable_out;
  int error_cnt = 0;
  int tests_run = 0;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h00006165;
  logic [31:0] ce_seed = 32'h00006165;
  logic [15:0] model = 16'h3120;

  always #20 mclk_in = ~mclk_in;

  p2mii_regs #(.PHY_ID_LOW(ID_LO), .PHY_ID_HIGH(ID_HI)) u_p2mii_regs (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .link_up_in(link_up_in), .autoneg_done_in(autoneg_done_in),
    .far_end_loopback_out(far_end_loopback_out),
    .autoneg_enable_out(autoneg_enable_out),
    .speed_select_fast_out(speed_select_fast_out),
    .full_duplex_out(full_duplex_out), .power_down_out(power_down_out),
    .autoneg_restart_out(autoneg_restart_out),
    .crossover_algorithm_select_out(crossover_algorithm_select_out),
    .auto_crossover_disable_out(auto_crossover_disable_out),
    .force_crossed_wiring_out(force_crossed_wiring_out),
    .tx_disable_out(tx_disable_out), .irq_out(irq_out));

  // Xorshift source; a fixed start keeps every run the same.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction

  task automatic print_verdict();
    $display("checks %0d errors %0d left %0d", tests_run, error_cnt,
             exp_q.size());
    if (error_cnt == 0 && tests_run > 0 && exp_q.size() == 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic timeout(input string what);
    error_cnt++;
    $display("[ERR] %0t %s timed out", $time, what);
    print_verdict();
  endtask

  // Returns at the rising edge where waitrequest is sampled low.
  task automatic wait_ack();
    for (int n = 0; n < 64; n++) begin
      @(posedge mclk_in);
      if (avs_waitrequest_out === 1'b0) return;
    end
    timeout("bus answer");
  endtask

  task automatic wait_irq(input logic lvl);
    for (int n = 0; n < 20; n++) begin
      @(posedge mclk_in);
      if (irq_out === lvl) return;
    end
    timeout("interrupt level");
  endtask

  // Each request starts at least one edge after the last release, so no strobe
  // is assigned twice in one time step.
  task automatic bus_rd(input logic [5:0] a, input logic [31:0] exp);
    @(posedge mclk_in);
    exp_q.push_back(exp);
    avs_address_in <= a;
    avs_read_in <= 1'b1;
    wait_ack();
    avs_read_in <= 1'b0;
  endtask

  task automatic bus_wr(input logic [5:0] a, input logic [31:0] d,
                        input logic [3:0] be);
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_write_in <= 1'b1;
    wait_ack();
    avs_write_in <= 1'b0;
  endtask

  task automatic chk_outs(input logic [15:0] c);
    chk({23'h0, far_end_loopback_out, speed_select_fast_out,
         autoneg_enable_out, power_down_out, full_duplex_out,
         crossover_algorithm_select_out, force_crossed_wiring_out,
         auto_crossover_disable_out, tx_disable_out},
        {23'h0, c[14], c[13], c[12], c[11], c[8], c[5], c[4], c[3], c[1]},
        "control outputs");
  endtask

  // Lanes that are off and read-only bits must keep the old value.
  task automatic wr_ctrl(input logic [31:0] d, input logic [3:0] be);
    logic [15:0] lm;
    lm = {{8{be[1]}}, {8{be[0]}}} & `P2M_CTRL_WMASK;
    model = (model & ~lm) | (d[15:0] & lm);
    bus_wr(6'h00, d, be);
    @(negedge mclk_in);
    chk({31'h0, autoneg_restart_out}, {31'h0, d[9] & be[1]}, "pulse");
    @(negedge mclk_in);
    chk({31'h0, autoneg_restart_out}, 32'h0, "pulse width");
    chk_outs(model);
    @(posedge mclk_in);
    bus_rd(6'h00, {16'h0, model});
  endtask

  // Clock enable is solid high except in the phase that stalls it.
  always @(posedge mclk_in) begin
    ce_seed <= xs(ce_seed);
    ce_in <= ce_rand ? ce_seed[7] : 1'b1;
  end

  // Each answered read takes the oldest expected word off the queue.
  always @(posedge mclk_in) begin
    if (rst_n_in === 1'b1 && avs_read_in === 1'b1 &&
        avs_waitrequest_out === 1'b0) begin
      if (exp_q.size() == 0) begin
        chk(avs_readdata_out, 32'hffffffff, "unexpected answer");
      end else begin
        chk(avs_readdata_out, exp_q.pop_front(), "read data");
      end
    end
  end

  initial begin
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    bus_rd(6'h00, 32'h00003120);
    chk_outs(16'h3120);
    bus_rd(6'h08, 32'h00007808);
    bus_rd(6'h10, {16'h0, ID_LO});
    bus_rd(6'h18, {16'h0, ID_HI});
    // Read-only places, an unmapped word and a misaligned address.
    bus_wr(6'h08, 32'hffffffff, 4'hf);
    bus_wr(6'h10, 32'h00000000, 4'hf);
    bus_wr(6'h18, 32'h00000000, 4'hf);
    bus_rd(6'h08, 32'h00007808);
    bus_rd(6'h10, {16'h0, ID_LO});
    bus_rd(6'h18, {16'h0, ID_HI});
    bus_rd(6'h2c, 32'h00000000);
    bus_rd(6'h09, 32'h00000000);
    wr_ctrl(32'hffffffff, 4'hf);
    wr_ctrl(32'h00000000, 4'hf);
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      wr_ctrl(seed, seed[19:16]);
    end
    // Stalled clock enable only stretches the answer.
    ce_rand <= 1'b1;
    for (int i = 0; i < 6; i++) bus_rd(6'h00, {16'h0, model});
    ce_rand <= 1'b0;
    repeat (3) @(posedge mclk_in);
    bus_wr(6'h24, 32'h00000003, 4'h1);
    bus_rd(6'h24, 32'h00000003);
    link_up_in <= 1'b1;
    wait_irq(1'b1);
    bus_rd(6'h08, 32'h0000780c);
    bus_rd(6'h20, 32'h00000001);
    bus_wr(6'h20, 32'h00000001, 4'h1);
    wait_irq(1'b0);
    autoneg_done_in <= 1'b1;
    wait_irq(1'b1);
    bus_rd(6'h08, 32'h0000782c);
    bus_rd(6'h20, 32'h00000002);
    bus_wr(6'h24, 32'h00000000, 4'h1);
    wait_irq(1'b0);
    bus_wr(6'h20, 32'h00000002, 4'h0);
    bus_rd(6'h20, 32'h00000002);
    bus_wr(6'h20, 32'h00000002, 4'h1);
    link_up_in <= 1'b0;
    repeat (8) @(posedge mclk_in);
    chk({31'h0, irq_out}, 32'h0, "masked irq");
    bus_rd(6'h20, 32'h00000001);
    bus_wr(6'h24, 32'h00000001, 4'h1);
    wait_irq(1'b1);
    bus_wr(6'h20, 32'h00000001, 4'h1);
    wait_irq(1'b0);
    bus_rd(6'h08, 32'h00007828);
    // A second reset in mid-run restores the defaults; negotiation is
    // dropped so no true rising edge follows the release.
    rst_n_in <= 1'b0;
    autoneg_done_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    chk({31'h0, irq_out}, 32'h0, "irq after reset");
    bus_rd(6'h00, 32'h00003120);
    chk_outs(16'h3120);
    bus_rd(6'h20, 32'h00000000);
    @(posedge mclk_in);
    print_verdict();
  end
endmodule

`default_nettype wire
